// file: hw/rom_decoder.sv
// Function
// - Wait-states selectable: 1, 2, 3 or 5
// - One wait: ROM at most 120 ns
// - Two waits: ROM at most 170 ns
// - Three waits: ROM at most 220 ns
// - Five waits: ROM at most 320 ns
// - Select ROM for 00800000 to 0083ffff
// - Four 64K parts fill window, no repeat
// - Smaller parts ignore upper address, contents repeat
// - 32K parts mirror at 00820000 upward
// - Socket bytes on fixed lanes, first highest
// - Image holds stack pointer, then program counter
// - After reset, addresses 0 and 4 read ROM
// - After both fetches, low memory returns to RAM
// - Size jumper picks 8K, 16K, 32K, 64K
//
// Purpose: Decodes processor cycles to the ROM window and low overlay.
// Assumes: Bus request held until ack; one request at a time.
// Notes: Jumpers are static straps; each passes two flops before use.
`timescale 1ns/100ps
module rom_decoder (
  rom_sock_if.decoder link,
  input wire logic srst,
  input wire rom_if_pkg::wait_sel_t wait_count_jumper,
  input wire rom_if_pkg::size_sel_t device_size_jumper,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic ram_sel,
  output logic overlay_active
);
  import rom_if_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } state_t;

  // ==========================================
  // Address decode helpers
  function automatic logic in_window(input logic [31:0] a);
    in_window = (a >= ROM_BASE) && (a <= ROM_LAST);
  endfunction : in_window

  function automatic logic [SOCK_AW-1:0] sock_index(input logic [31:0] a, input size_sel_t sz);
    logic [SOCK_AW-1:0] idx;
    idx = a[LANE_LSB +: SOCK_AW];
    // Upper bits above part size dropped, so small parts mirror
    case (sz)
      SIZE_8K: sock_index = idx & SOCK_MASK_8K;
      SIZE_16K: sock_index = idx & SOCK_MASK_16K;
      SIZE_32K: sock_index = idx & SOCK_MASK_32K;
      default: sock_index = idx;
    endcase
  endfunction : sock_index

  function automatic logic is_vector(input logic [31:0] a);
    is_vector = (a[31:LANE_LSB] == VEC_SP_ADDR[31:LANE_LSB]) ||
                (a[31:LANE_LSB] == VEC_PC_ADDR[31:LANE_LSB]);
  endfunction : is_vector

  // Ack, data capture and fetch count all key off this one point
  function automatic logic last_wait(input state_t s, input logic [2:0] w);
    last_wait = (s == ST_WAIT) && (w == WAIT_LAST);
  endfunction : last_wait

  // ==========================================
  // Jumper synchronisers
  // Straps are wired off-board, so two flops stand before any decode
  wait_sel_t wait_meta_reg;
  wait_sel_t wait_sync_reg;
  size_sel_t size_meta_reg;
  size_sel_t size_sync_reg;

  always_ff @(posedge link.clock) begin
    wait_meta_reg <= wait_count_jumper;
    wait_sync_reg <= wait_meta_reg;
  end

  always_ff @(posedge link.clock) begin
    size_meta_reg <= device_size_jumper;
    size_sync_reg <= size_meta_reg;
  end

  // ==========================================
  // State
  state_t state_reg;
  logic [2:0] wait_reg;
  logic [1:0] fetch_reg;
  logic cycle_is_vec_reg;
  logic hit;
  logic vec_hit;
  logic take;
  logic end_cycle;

  assign vec_hit = overlay_active && is_vector(bus_addr) && !bus_write;
  assign hit = in_window(bus_addr) || vec_hit;
  assign take = (state_reg == ST_IDLE) && bus_req && hit;
  assign end_cycle = last_wait(state_reg, wait_reg);

  always_ff @(posedge link.clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (end_cycle) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!bus_req) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Wait-state counter, loaded as the cycle is taken
  always_ff @(posedge link.clock) begin
    if (srst) begin
      wait_reg <= 3'h0;
    end else if (take) begin
      wait_reg <= wait_count(wait_sync_reg);
    end else if (state_reg == ST_WAIT) begin
      wait_reg <= wait_reg - 3'h1;
    end
  end

  // Marked at take, as the overlay may drop before the cycle ends
  always_ff @(posedge link.clock) begin
    if (srst) begin
      cycle_is_vec_reg <= 1'b0;
    end else if (take) begin
      cycle_is_vec_reg <= vec_hit;
    end
  end

  // ==========================================
  // Socket drive
  always_ff @(posedge link.clock) begin
    if (srst) begin
      link.sock_addr <= '0;
      link.sock_ce_n <= 1'b1;
      link.sock_oe_n <= 1'b1;
    end else begin
      if (take) begin
        link.sock_addr <= vec_hit ? {{(SOCK_AW-1){1'b0}}, bus_addr[LANE_LSB]}
                                  : sock_index(bus_addr, size_sync_reg);
        link.sock_ce_n <= 1'b0;
        // Write cycles never enable output, contents untouched
        link.sock_oe_n <= bus_write;
      end else if (state_reg == ST_DONE && !bus_req) begin
        link.sock_ce_n <= 1'b1;
        link.sock_oe_n <= 1'b1;
      end
    end
  end

  // ==========================================
  // Bus answer
  always_ff @(posedge link.clock) begin
    if (srst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= end_cycle;
    end
  end

  // Held until the next ack, so a slow master may still take it
  always_ff @(posedge link.clock) begin
    if (srst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (end_cycle) begin
      bus_rdata <= link.sock_oe_n ? 32'h0000_0000 : link.sock_data;
    end
  end

  // RAM selected for low memory unless the overlay is serving it
  always_ff @(posedge link.clock) begin
    if (srst) begin
      ram_sel <= 1'b0;
    end else begin
      ram_sel <= bus_req && !hit && (bus_addr < ROM_BASE);
    end
  end

  // ==========================================
  // Overlay fetch counter
  always_ff @(posedge link.clock) begin
    if (srst) begin
      fetch_reg <= 2'h0;
      overlay_active <= 1'b1;
    end else if (end_cycle && cycle_is_vec_reg) begin
      fetch_reg <= fetch_reg + 2'h1;
      if (fetch_reg + 2'h1 == FETCH_DONE) begin
        overlay_active <= 1'b0;
      end
    end
  end
endmodule : rom_decoder

// file: hw/rom_if_pkg.sv
// Purpose: Shared constants and types for the boot ROM interface ends.
// Assumes: 32-bit processor bus, four byte-wide sockets, one 20 MHz clock.
// Notes: Both ends import this package.
package rom_if_pkg;
  // ==========================================
  // Address window
  localparam logic [31:0] ROM_BASE = 32'h0080_0000;
  localparam logic [31:0] ROM_LAST = 32'h0083_ffff;
  localparam logic [31:0] VEC_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] VEC_PC_ADDR = 32'h0000_0004;
  localparam int WIN_AW = 18;
  localparam int SOCK_AW = 16;
  localparam int LANE_LSB = 2;
  localparam logic [1:0] FETCH_DONE = 2'h2;
  // Socket index masks for the three smaller part depths
  localparam logic [SOCK_AW-1:0] SOCK_MASK_8K = 16'h1fff;
  localparam logic [SOCK_AW-1:0] SOCK_MASK_16K = 16'h3fff;
  localparam logic [SOCK_AW-1:0] SOCK_MASK_32K = 16'h7fff;
  // Wait count seen on the last wait-state of a cycle
  localparam logic [2:0] WAIT_LAST = 3'h1;
  // ==========================================
  // Jumper encodings
  typedef enum logic [1:0] {
    WAIT_1 = 2'b00,
    WAIT_2 = 2'b01,
    WAIT_3 = 2'b10,
    WAIT_5 = 2'b11
  } wait_sel_t;
  typedef enum logic [1:0] {
    SIZE_8K = 2'b00,
    SIZE_16K = 2'b01,
    SIZE_32K = 2'b10,
    SIZE_64K = 2'b11
  } size_sel_t;
  localparam logic [2:0] WAIT_N1 = 3'h1;
  localparam logic [2:0] WAIT_N2 = 3'h2;
  localparam logic [2:0] WAIT_N3 = 3'h3;
  localparam logic [2:0] WAIT_N5 = 3'h5;
  // ==========================================
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // Allowed access times at 20 MHz for 1, 2, 3, 5 wait-states
  localparam int ACC_NS_W1 = 120;
  localparam int ACC_NS_W2 = 170;
  localparam int ACC_NS_W3 = 220;
  localparam int ACC_NS_W5 = 320;
  // Longest times round down to whole cycles
  localparam int ACC_CYC_W1 = (ACC_NS_W1 / CLK_PERIOD_NS) < 1 ? 1 : ACC_NS_W1 / CLK_PERIOD_NS;
  localparam int ACC_CYC_W2 = (ACC_NS_W2 / CLK_PERIOD_NS) < 1 ? 1 : ACC_NS_W2 / CLK_PERIOD_NS;
  localparam int ACC_CYC_W3 = (ACC_NS_W3 / CLK_PERIOD_NS) < 1 ? 1 : ACC_NS_W3 / CLK_PERIOD_NS;
  localparam int ACC_CYC_W5 = (ACC_NS_W5 / CLK_PERIOD_NS) < 1 ? 1 : ACC_NS_W5 / CLK_PERIOD_NS;

  function automatic logic [2:0] wait_count(input wait_sel_t sel);
    case (sel)
      WAIT_1: wait_count = WAIT_N1;
      WAIT_2: wait_count = WAIT_N2;
      WAIT_3: wait_count = WAIT_N3;
      default: wait_count = WAIT_N5;
    endcase
  endfunction : wait_count

  function automatic int acc_cycles(input wait_sel_t sel);
    case (sel)
      WAIT_1: acc_cycles = ACC_CYC_W1;
      WAIT_2: acc_cycles = ACC_CYC_W2;
      WAIT_3: acc_cycles = ACC_CYC_W3;
      default: acc_cycles = ACC_CYC_W5;
    endcase
  endfunction : acc_cycles
endpackage : rom_if_pkg

// file: hw/rom_sock_if.sv
// Purpose: Socket-side link between the decoder and the four ROM sockets.
// Assumes: One clock; all four sockets share address and enables.
// Notes: Read-only sockets, so no two-way pins are needed.
`timescale 1ns/100ps
interface rom_sock_if (
  input wire logic clock
);
  import rom_if_pkg::*;
  logic [rom_if_pkg::SOCK_AW-1:0] sock_addr;
  logic sock_ce_n;
  logic sock_oe_n;
  logic [31:0] sock_data;
  modport decoder (
    input clock,
    output sock_addr,
    output sock_ce_n,
    output sock_oe_n,
    input sock_data
  );
  modport sockets (
    input clock,
    input sock_addr,
    input sock_ce_n,
    input sock_oe_n,
    output sock_data
  );
endinterface : rom_sock_if

// file: hw/rom_sockets.sv
// Purpose: Four byte-wide ROM sockets answering the decoder's address.
// Assumes: Contents loaded by the user port; read after the access time.
// Notes: Access time counted from the address change, in whole cycles.
`timescale 1ns/100ps
module rom_sockets (
  rom_sock_if.sockets link,
  input wire logic srst,
  input wire rom_if_pkg::wait_sel_t wait_count_jumper,
  input wire logic load_en,
  input wire logic [1:0] load_lane,
  input wire logic [rom_if_pkg::SOCK_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  output logic access_ok
);
  import rom_if_pkg::*;
  // ==========================================
  // Storage, one array per socket lane
  logic [7:0] mem0 [0:(1<<SOCK_AW)-1];
  logic [7:0] mem1 [0:(1<<SOCK_AW)-1];
  logic [7:0] mem2 [0:(1<<SOCK_AW)-1];
  logic [7:0] mem3 [0:(1<<SOCK_AW)-1];
  logic [SOCK_AW-1:0] addr_reg;
  logic [3:0] age_reg;
  logic [31:0] word_rd;

  always_ff @(posedge link.clock) begin
    if (load_en) begin
      case (load_lane)
        2'h3: mem0[load_addr] <= load_data;
        2'h2: mem1[load_addr] <= load_data;
        2'h1: mem2[load_addr] <= load_data;
        default: mem3[load_addr] <= load_data;
      endcase
    end
  end

  // Fitted parts must settle within the selected access time
  always_ff @(posedge link.clock) begin
    if (srst) begin
      addr_reg <= '0;
      age_reg <= '0;
      access_ok <= 1'b0;
    end else begin
      addr_reg <= link.sock_addr;
      if (link.sock_addr != addr_reg || link.sock_ce_n) begin
        age_reg <= '0;
      end else if (age_reg != 4'hf) begin
        age_reg <= age_reg + 4'h1;
      end
      access_ok <= (32'(age_reg) + 32'd1) >= 32'(acc_cycles(wait_count_jumper));
    end
  end

  // Image places stack pointer and program counter first
  // Read follows the address at once; a register here would hand the decoder
  // the previous word on a one wait-state cycle
  always_comb begin
    word_rd = {mem0[link.sock_addr], mem1[link.sock_addr],
               mem2[link.sock_addr], mem3[link.sock_addr]};
  end

  assign link.sock_data = (link.sock_ce_n || link.sock_oe_n) ? 32'h0000_0000 : word_rd;
endmodule : rom_sockets

// file: testbench/rom_if_chk.sv
// Purpose: Timing checks on the decoder bus and socket link
// Assumes: One clock, sync active-high reset
// Notes: Instantiated beside the link, no bind
`timescale 1ns/100ps
module rom_if_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic sock_ce_n,
  input wire logic sock_oe_n,
  input wire logic [rom_if_pkg::SOCK_AW-1:0] sock_addr,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_ack,
  input wire logic overlay_active,
  input wire rom_if_pkg::wait_sel_t wait_count_jumper
);
  import rom_if_pkg::*;
  // ==========================================
  // Wait-state timing, from enable to ack
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  AST_WAIT_ONE: assert property (
    (wait_count_jumper == WAIT_1 && $fell(sock_ce_n)) |-> !bus_ack [*1] ##1 bus_ack)
    else $error("ack timing wrong for one wait");
  AST_WAIT_TWO: assert property (
    (wait_count_jumper == WAIT_2 && $fell(sock_ce_n)) |-> !bus_ack [*2] ##1 bus_ack)
    else $error("ack timing wrong for two waits");
  AST_WAIT_THREE: assert property (
    (wait_count_jumper == WAIT_3 && $fell(sock_ce_n)) |-> !bus_ack [*3] ##1 bus_ack)
    else $error("ack timing wrong for three waits");
  AST_WAIT_FIVE: assert property (
    (wait_count_jumper == WAIT_5 && $fell(sock_ce_n)) |-> !bus_ack [*5] ##1 bus_ack)
    else $error("ack timing wrong for five waits");
  AST_ACK_PULSE: assert property (bus_ack |=> !bus_ack)
    else $error("ack longer than one cycle");
  // Address must not move under a slow part
  AST_CE_HOLD: assert property (
    (!sock_ce_n && bus_req) |=> (!sock_ce_n && $stable(sock_addr)))
    else $error("socket select or address moved mid cycle");
  AST_WRITE_NO_OE: assert property ((bus_ack && bus_write) |-> sock_oe_n)
    else $error("socket output enabled on write");
  // ==========================================
  // Low-memory overlay
  AST_OVL_ARMED: assert property ($fell(srst) |-> overlay_active)
    else $error("overlay not armed after reset");
  AST_OVL_DROP: assert property ($fell(overlay_active) |-> (bus_ack && !bus_write))
    else $error("overlay dropped without a read ack");
  AST_OVL_STAY: assert property (!overlay_active |=> !overlay_active)
    else $error("overlay came back without reset");
endmodule : rom_if_chk

// file: testbench/tb_boot_rom_interface.sv
// Purpose: Drives both ends of the boot ROM link
// Assumes: Jumpers changed only while the bus is idle
// Notes: Requests held until ack or 12 edges, two idle cycles between
`timescale 1ns/100ps
module tb_boot_rom_interface;
  import rom_if_pkg::*;
  localparam logic [31:0] W0 = 32'h0123_4567;
  localparam logic [31:0] W1 = 32'h89ab_cdef;
  localparam logic [31:0] W2 = 32'h5a5a_0ff0;
  logic clock = 1'b0;
  logic srst = 1'b1;
  wait_sel_t wsel = WAIT_1;
  size_sel_t dsz = SIZE_64K;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic load_en = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [1:0] ld_lane = 2'h0;
  logic [15:0] ld_addr = 16'h0;
  logic [7:0] ld_data = 8'h0;
  logic [31:0] rd;
  logic ack, ram_sel, ovl, hit_ram;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc;
  rom_sock_if u_rom_sock_if (.clock(clock));
  rom_decoder u_rom_decoder (.link(u_rom_sock_if), .srst(srst), .wait_count_jumper(wsel),
    .device_size_jumper(dsz), .bus_req(req), .bus_write(wr), .bus_addr(addr),
    .bus_ack(ack), .bus_rdata(rd), .ram_sel(ram_sel), .overlay_active(ovl));
  rom_sockets u_rom_sockets (.link(u_rom_sock_if), .srst(srst), .wait_count_jumper(wsel),
    .load_en(load_en), .load_lane(ld_lane), .load_addr(ld_addr), .load_data(ld_data),
    .access_ok());
  rom_if_chk u_rom_if_chk (.clock(clock), .srst(srst), .sock_ce_n(u_rom_sock_if.sock_ce_n),
    .sock_oe_n(u_rom_sock_if.sock_oe_n), .sock_addr(u_rom_sock_if.sock_addr),
    .bus_req(req), .bus_write(wr), .bus_ack(ack), .overlay_active(ovl),
    .wait_count_jumper(wsel));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic do_reset();
    @(posedge clock);
    srst <= 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
  endtask : do_reset
  // Lane 3 is the first socket, top byte
  task automatic load(input logic [15:0] idx, input logic [31:0] w);
    for (int i = 3; i >= 0; i--) begin
      @(posedge clock);
      load_en <= 1'b1;
      ld_lane <= 2'(i);
      ld_addr <= idx;
      ld_data <= w[8*i +: 8];
    end
    @(posedge clock);
    load_en <= 1'b0;
  endtask : load
  // Edges from drive to ack seen; 0 when nobody answers
  task automatic bus(input logic w, input logic [31:0] a);
    @(posedge clock);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    cyc = 0;
    hit_ram = 1'b0;
    do begin
      @(posedge clock);
      cyc++;
      hit_ram |= ram_sel;
    end while (ack !== 1'b1 && cyc < 12);
    req <= 1'b0;
    if (ack !== 1'b1) cyc = 0;
    @(posedge clock);
  endtask : bus
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input int n);
    bus(1'b0, a);
    check(32'(cyc), 32'(n));
    if (n != 0) check(rd, exp);
  endtask : rd_chk
  // ==========================================
  // Scenarios
  task automatic t_vectors();
    check(32'(ovl), 32'h1);
    rd_chk(VEC_SP_ADDR, W0, 3);
    rd_chk(VEC_PC_ADDR, W1, 3);
    check(32'(ovl), 32'h0);
    bus(1'b0, VEC_SP_ADDR);
    check({cyc[30:0], hit_ram}, 32'h1);
    do_reset();
    load(16'h1, W1);
    rd_chk(VEC_PC_ADDR, W1, 3);
    $display("vectors test done");
  endtask : t_vectors
  task automatic t_waits();
    int n[4] = '{1, 2, 3, 5};
    for (int i = 0; i < 4; i++) begin
      wsel <= wait_sel_t'(i);
      // Straps cross two decoder flops before a cycle may use them
      repeat (2) @(posedge clock);
      rd_chk(ROM_BASE + 32'h4, W1, n[i] + 2);
      bus(1'b1, ROM_BASE);
      check(32'(cyc), 32'(n[i] + 2));
    end
    rd_chk(ROM_BASE, W0, 7);
    $display("waits test done");
  endtask : t_waits
  task automatic t_window();
    load(16'h8000, W2);
    load(16'hffff, W1);
    load(16'h7fff, W2);
    rd_chk(32'h0082_0000, W2, 7);
    rd_chk(ROM_LAST - 32'h3, W1, 7);
    rd_chk(ROM_LAST + 32'h1, W0, 0);
    check(32'(hit_ram), 32'h0);
    rd_chk(ROM_BASE - 32'h4, W0, 0);
    check(32'(hit_ram), 32'h1);
    // Offset of one socket depth folds back to word zero
    for (int s = 0; s < 3; s++) begin
      dsz <= size_sel_t'(s);
      repeat (2) @(posedge clock);
      rd_chk(ROM_BASE + (32'h8000 << s), W0, 7);
    end
    // Top word of the upper half mirrors index 7fff of 32K parts
    rd_chk(ROM_LAST - 32'h3, W2, 7);
    $display("window test done");
  endtask : t_window
  // ==========================================
  // Clock, watchdog, main sequence
  initial begin
    forever #25 clock = ~clock;
  end
  // Run needs well under 1000 cycles
  initial begin
    #(50 * 3000);
    n_fail++;
    stop_test();
  end
  initial begin
    do_reset();
    load(16'h0, W0);
    load(16'h1, W1);
    t_vectors();
    t_waits();
    t_window();
    stop_test();
  end
endmodule : tb_boot_rom_interface
